// file: epp_ecp_pkg.sv
// Purpose: shared constants and types for the parallel host port
// Assumes: APB word registers, byte address is four times the index
// Notes:   cycle counts are derived from the clock rate inside the module
package epp_ecp_pkg;
  localparam int ADDR_W = 16;
  // register indices
  localparam logic [11:0] IDX_PORT_DATA    = 12'h000;
  localparam logic [11:0] IDX_LINE_STATUS  = 12'h001;
  localparam logic [11:0] IDX_LINE_CONTROL = 12'h002;
  localparam logic [11:0] IDX_EPP_ADDR     = 12'h003;
  localparam logic [11:0] IDX_EPP_DATA0    = 12'h004;
  localparam logic [11:0] IDX_EPP_DATA3    = 12'h007;
  localparam logic [11:0] IDX_QUEUE        = 12'h400;
  localparam logic [11:0] IDX_CAP_B        = 12'h401;
  localparam logic [11:0] IDX_MODE_CTRL    = 12'h402;
  localparam logic [11:0] IDX_CHIP_OPT     = 12'h403;
  // field positions
  localparam int CTRL_DIR_BIT    = 5;
  localparam int OPT_EPP_EN_BIT  = 0;
  localparam int OPT_EPP_V19_BIT = 1;
  localparam int STAT_CYCLE_TIMEOUT_FLAG_BIT  = 0;
  // reset and fixed values
  localparam logic [5:0] CTRL_RST      = 6'h04;
  localparam logic [2:0] MODE_RST      = 3'h0;
  localparam logic [2:0] MODE_BITS_RST = 3'h5;
  localparam logic [5:0] CAP_B_RST     = 6'h07;
  localparam logic [1:0] CHIP_OPT_RST  = 2'h0;
  localparam logic [7:0] CAP_A_VALUE   = 8'h10;
  // timing, in nanoseconds
  localparam longint EPP_TIMEOUT_NS = 10000;
  localparam longint STROBE_NS      = 500;
  localparam longint NS_PER_S       = 1000000000;

  typedef enum logic [2:0] {
    MODE_SPP    = 3'b000,
    MODE_PS2    = 3'b001,
    MODE_FIFO   = 3'b010,
    MODE_ECP    = 3'b011,
    MODE_EPP    = 3'b100,
    MODE_RSVD   = 3'b101,
    MODE_TEST   = 3'b110,
    MODE_CONFIG = 3'b111
  } port_mode_e;

  typedef struct packed {
    logic [7:0] pd;
    logic       busy;
    logic       ack_n;
    logic       perror;
    logic       select;
    logic       fault_n;
  } par_in_s;

  typedef struct packed {
    logic [7:0] pd;
    logic       pd_oe;
    logic       strobe_n;
    logic       autofd_n;
    logic       init_n;
    logic       selectin_n;
  } par_out_s;
endpackage

// file: epp_ecp_parallel_port.sv
// Purpose: multi-mode parallel port with EPP cycles, FIFO modes and ECP
// Assumes: cable inputs already synchronous to pclk
// Notes:   EPP accesses stall the APB access phase until the cable cycle ends
// Behaviour
// - data strobe low marks an EPP data cycle, read or write
// - address strobe low marks an EPP address cycle, read or write
// - init line low returns the peripheral to its initial mode
// - idle EPP cable follows control register, direction from the direction bit
// - cycle longer than ten microseconds is aborted and status bit 0 set
// - address write, data write, address read and data read cycles
// - newer protocol: start with wait low, finish on wait high, write line low
// - newer protocol: no cycle starts while wait is high
// - older protocol: start at once, finish only after wait rises
// - sixteen byte queue serves forward and reverse transfers
// - reverse count byte makes the following byte repeat in hardware
// - upper group decoded by offset and mode
// - mode taken from mode control bits 7 to 5
// - EPP mode honoured only when enabled in chip options
// - standard modes latch writes onto data lines, reads return the lines
// - ECP forward write at base offset queues an address tagged byte
// - DMA moves ECP traffic in both directions
// - compatibility FIFO mode runs the printer handshake in hardware
// - writing one clears the time-out flag, zero leaves it
// - direction bit one makes data lines inputs, zero outputs; plain printer and compat FIFO modes keep them outputs
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module epp_ecp_parallel_port
  import epp_ecp_pkg::*;
#(
  parameter int CLK_HZ = 25000000,
  parameter int DEPTH  = 16
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // parallel cable
  input  wire par_in_s           pins_i,
  output par_out_s               pins_o,
  // dma channel
  output logic                   dma_req,
  input  wire logic              dma_ack,
  input  wire logic [7:0]        dma_wdata,
  output logic      [7:0]        dma_rdata
);
  localparam longint TO_L = (EPP_TIMEOUT_NS * CLK_HZ) / NS_PER_S;
  localparam longint ST_L = (STROBE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam logic [15:0] TIMEOUT_CYC = TO_L[15:0];
  localparam logic [15:0] STROBE_CYC  = (ST_L < 1) ? 16'h0001 : ST_L[15:0];
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (TO_L < 1 || TO_L > 65535 || ST_L > 65535) $error("clock rate out of range");
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
  end

  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_WAIT   = 2'b01,
    E_STROBE = 2'b10,
    E_DONE   = 2'b11
  } epp_e;

  typedef enum logic [2:0] {
    X_IDLE   = 3'b000,
    X_SETUP  = 3'b001,
    X_STROBE = 3'b010,
    X_HOLD   = 3'b011,
    X_RWAIT  = 3'b100,
    X_RACK   = 3'b101,
    X_RLE    = 3'b110
  } xfer_e;

  // registers
  logic [7:0]  data_reg;
  logic [5:0]  ctrl_reg;
  port_mode_e  mode_reg;
  logic [2:0]  mode_bits_reg;
  logic [5:0]  cap_b_reg;
  logic [1:0]  chip_opt_reg;
  logic        timeout_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  // epp engine
  epp_e        e_state;
  logic [15:0] epp_cnt_reg;
  logic        epp_write_reg;
  logic        epp_addr_reg;
  logic        epp_seen_low_reg;
  logic [7:0]  epp_wdata_reg;
  // queue and transfer engine
  logic [8:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  xfer_e       x_state;
  logic [15:0] x_cnt_reg;
  logic [7:0]  xfer_data_reg;
  logic        xfer_tag_reg;
  logic [6:0]  rle_cnt_reg;
  logic [6:0]  rle_rep_reg;

  logic [11:0] idx;
  logic        in_range, dec_ok, is_epp, setup, access_done, apb_wr, apb_rd;
  logic [7:0]  rd_val;
  logic        epp_active, dir_eff, opt_v19, full, empty, fwd_run, rev_run;
  logic        epp_done, epp_tmo, epp_start;
  logic        push, pop, push_tag, q_push_apb, q_pop_apb, dma_on, dma_push, dma_pop;
  logic        eng_push, eng_pop;
  logic [7:0]  push_data;

  assign idx        = paddr[13:2];
  assign in_range   = (paddr[ADDR_W-1:14] == '0) && (paddr[1:0] == 2'b00);
  assign epp_active = (mode_reg == MODE_EPP) && chip_opt_reg[OPT_EPP_EN_BIT];
  assign opt_v19    = chip_opt_reg[OPT_EPP_V19_BIT];
  // direction is forced out in plain printer and compat FIFO modes
  assign dir_eff    = ctrl_reg[CTRL_DIR_BIT]
                      && !(mode_reg == MODE_SPP || mode_reg == MODE_FIFO);
  assign full       = count_reg == DEPTH[PW:0];
  assign empty      = count_reg == '0;
  assign fwd_run    = (mode_reg == MODE_FIFO) || (mode_reg == MODE_ECP && !dir_eff);
  assign rev_run    = (mode_reg == MODE_ECP) && dir_eff;
  assign setup      = psel && !penable;
  assign access_done = psel && penable && pready;
  assign apb_wr     = access_done && pwrite && dec_ok;
  assign apb_rd     = access_done && !pwrite && dec_ok;

  always_comb begin
    dec_ok = in_range;
    is_epp = 1'b0;
    rd_val = 8'h00;
    case (idx)
      IDX_PORT_DATA:    rd_val = pins_i.pd;
      IDX_LINE_STATUS:  rd_val = {~pins_i.busy, pins_i.ack_n, pins_i.perror, pins_i.select,
                                  pins_i.fault_n, 2'b11, timeout_reg};
      IDX_LINE_CONTROL: rd_val = {2'b11, ctrl_reg};
      IDX_EPP_ADDR, IDX_EPP_DATA0, 12'h005, 12'h006, IDX_EPP_DATA3: begin
        is_epp = epp_active && in_range;
        dec_ok = is_epp;
      end
      IDX_QUEUE: begin
        dec_ok = in_range && (mode_reg == MODE_FIFO || mode_reg == MODE_ECP
                              || mode_reg == MODE_TEST || mode_reg == MODE_CONFIG);
        rd_val = (mode_reg == MODE_CONFIG) ? CAP_A_VALUE : mem[rd_ptr_reg][7:0];
      end
      IDX_CAP_B: begin
        dec_ok = in_range && (mode_reg == MODE_CONFIG);
        rd_val = {2'b00, cap_b_reg};
      end
      IDX_MODE_CTRL:    rd_val = {mode_reg, mode_bits_reg, full, empty};
      IDX_CHIP_OPT:     rd_val = {6'h00, chip_opt_reg};
      default:          dec_ok = 1'b0;
    endcase
  end

  // apb answer; epp accesses wait for the cable cycle to finish
  assign pready  = is_epp ? (e_state == E_DONE) : 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (epp_done || epp_tmo) begin
      prdata_reg  <= {24'h000000, pins_i.pd};
      pslverr_reg <= epp_tmo;
    end else if (setup && !is_epp) begin
      prdata_reg  <= {24'h000000, rd_val};
      pslverr_reg <= !dec_ok;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg      <= 8'h00;
      ctrl_reg      <= CTRL_RST;
      mode_reg      <= port_mode_e'(MODE_RST);
      mode_bits_reg <= MODE_BITS_RST;
      cap_b_reg     <= CAP_B_RST;
      chip_opt_reg  <= CHIP_OPT_RST;
    end else if (apb_wr) begin
      case (idx)
        IDX_PORT_DATA:    if (mode_reg != MODE_ECP) data_reg <= pwdata[7:0];
        IDX_LINE_CONTROL: ctrl_reg <= pwdata[5:0];
        IDX_CAP_B:        cap_b_reg <= pwdata[5:0];
        IDX_MODE_CTRL: begin
          mode_reg      <= port_mode_e'(pwdata[7:5]);
          mode_bits_reg <= pwdata[4:2];
        end
        IDX_CHIP_OPT:     chip_opt_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // time-out flag: a new time-out wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timeout_reg <= 1'b0;
    else if (epp_tmo) timeout_reg <= 1'b1;
    else if (apb_wr && idx == IDX_LINE_STATUS && pwdata[STAT_CYCLE_TIMEOUT_FLAG_BIT])
      timeout_reg <= 1'b0;
  end

  // epp cycle engine
  assign epp_start = setup && is_epp && e_state == E_IDLE;
  assign epp_tmo   = (e_state == E_WAIT || e_state == E_STROBE)
                     && epp_cnt_reg >= TIMEOUT_CYC;
  assign epp_done  = !epp_tmo && e_state == E_STROBE && pins_i.busy
                     && (opt_v19 || epp_seen_low_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_state          <= E_IDLE;
      epp_cnt_reg      <= 16'h0000;
      epp_write_reg    <= 1'b0;
      epp_addr_reg     <= 1'b0;
      epp_seen_low_reg <= 1'b0;
      epp_wdata_reg    <= 8'h00;
    end else begin
      case (e_state)
        E_IDLE: if (epp_start) begin
          epp_write_reg    <= pwrite;
          epp_addr_reg     <= idx == IDX_EPP_ADDR;
          epp_wdata_reg    <= pwdata[7:0];
          epp_cnt_reg      <= 16'h0000;
          epp_seen_low_reg <= 1'b0;
          e_state <= (opt_v19 && pins_i.busy) ? E_WAIT : E_STROBE;
        end
        E_WAIT: begin
          epp_cnt_reg <= epp_cnt_reg + 16'h0001;
          if (epp_tmo) e_state <= E_DONE;
          else if (!pins_i.busy) e_state <= E_STROBE;
        end
        E_STROBE: begin
          epp_cnt_reg <= epp_cnt_reg + 16'h0001;
          if (!pins_i.busy) epp_seen_low_reg <= 1'b1;
          if (epp_tmo || epp_done) e_state <= E_DONE;
        end
        E_DONE: e_state <= E_IDLE;
        default: e_state <= E_IDLE;
      endcase
    end
  end

  // queue sources and sinks
  assign q_push_apb = apb_wr && !full && (
      (idx == IDX_QUEUE && (fwd_run || mode_reg == MODE_TEST))
      || (idx == IDX_PORT_DATA && mode_reg == MODE_ECP && !dir_eff));
  assign push_tag   = apb_wr && idx == IDX_PORT_DATA;
  assign q_pop_apb  = apb_rd && idx == IDX_QUEUE && !empty
                      && (rev_run || mode_reg == MODE_TEST);
  // dma is held off whenever psel is high, whatever register the bus addresses
  assign dma_on     = mode_bits_reg[1] && !mode_bits_reg[0] && !psel
                      && (mode_reg == MODE_FIFO || mode_reg == MODE_ECP || mode_reg == MODE_TEST);
  assign dma_req    = dma_on && (dir_eff ? !empty : !full);
  assign dma_push   = dma_req && dma_ack && !dir_eff;
  assign dma_pop    = dma_req && dma_ack && dir_eff;
  assign dma_rdata  = mem[rd_ptr_reg][7:0];
  assign push       = q_push_apb || dma_push || eng_push;
  assign pop        = q_pop_apb || dma_pop || eng_pop;
  assign push_data  = eng_push ? (x_state == X_RLE ? xfer_data_reg : pins_i.pd)
                    : (dma_push ? dma_wdata : pwdata[7:0]);

  always_ff @(posedge pclk) begin
    if (push) mem[wr_ptr_reg] <= {push_tag && !eng_push && !dma_push, push_data};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (mode_reg == MODE_SPP) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end

  // transfer engine: forward handshakes and reverse capture
  assign eng_pop  = x_state == X_IDLE && fwd_run && !empty && !pins_i.busy;
  assign eng_push = !full && ((x_state == X_RWAIT && !pins_i.ack_n
                              && (pins_i.busy || pins_i.pd[7]))
                             || (x_state == X_RLE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_state       <= X_IDLE;
      x_cnt_reg     <= 16'h0000;
      xfer_data_reg <= 8'h00;
      xfer_tag_reg  <= 1'b0;
      rle_cnt_reg   <= 7'h00;
      rle_rep_reg   <= 7'h00;
    end else if (!fwd_run && !rev_run) begin
      x_state <= X_IDLE;
    end else begin
      case (x_state)
        X_IDLE: begin
          x_cnt_reg <= 16'h0000;
          if (eng_pop) begin
            xfer_data_reg <= mem[rd_ptr_reg][7:0];
            xfer_tag_reg  <= mem[rd_ptr_reg][8];
            x_state       <= X_SETUP;
          end else if (rev_run && !full) x_state <= X_RWAIT;
        end
        X_SETUP: begin
          x_cnt_reg <= x_cnt_reg + 16'h0001;
          if (x_cnt_reg == STROBE_CYC - 16'h0001) begin
            x_cnt_reg <= 16'h0000;
            x_state   <= X_STROBE;
          end
        end
        X_STROBE: begin
          x_cnt_reg <= x_cnt_reg + 16'h0001;
          if (mode_reg == MODE_FIFO ? x_cnt_reg == STROBE_CYC - 16'h0001 : pins_i.busy) begin
            x_cnt_reg <= 16'h0000;
            x_state   <= X_HOLD;
          end
        end
        X_HOLD: begin
          x_cnt_reg <= x_cnt_reg + 16'h0001;
          if (mode_reg == MODE_FIFO ? x_cnt_reg == STROBE_CYC - 16'h0001 : !pins_i.busy)
            x_state <= X_IDLE;
        end
        X_RWAIT: if (!pins_i.ack_n) begin
          if (!pins_i.busy && !pins_i.pd[7]) begin
            rle_cnt_reg <= pins_i.pd[6:0];
            x_state     <= X_RACK;
          end else if (!full) begin
            xfer_data_reg <= pins_i.pd;
            rle_rep_reg   <= rle_cnt_reg;
            rle_cnt_reg   <= 7'h00;
            x_state       <= X_RACK;
          end
        end
        X_RACK: if (pins_i.ack_n) x_state <= (rle_rep_reg != 7'h00) ? X_RLE : X_IDLE;
        X_RLE: if (!full) begin
          rle_rep_reg <= rle_rep_reg - 7'h01;
          if (rle_rep_reg == 7'h01) x_state <= X_IDLE;
        end
        default: x_state <= X_IDLE;
      endcase
    end
  end

  // cable drive
  always_comb begin
    pins_o.pd         = data_reg;
    pins_o.pd_oe      = !dir_eff;
    pins_o.strobe_n   = ~ctrl_reg[0];
    pins_o.autofd_n   = ~ctrl_reg[1];
    pins_o.init_n     = ctrl_reg[2];
    pins_o.selectin_n = ~ctrl_reg[3];
    if (epp_active && e_state != E_IDLE) begin
      pins_o.pd         = epp_wdata_reg;
      pins_o.pd_oe      = epp_write_reg;
      pins_o.strobe_n   = !epp_write_reg;
      pins_o.autofd_n   = !(e_state == E_STROBE && !epp_addr_reg);
      pins_o.selectin_n = !(e_state == E_STROBE && epp_addr_reg);
    end else if (fwd_run && x_state != X_IDLE) begin
      pins_o.pd       = xfer_data_reg;
      pins_o.pd_oe    = 1'b1;
      pins_o.strobe_n = x_state != X_STROBE;
      if (mode_reg == MODE_ECP) pins_o.autofd_n = !xfer_tag_reg;
    end else if (rev_run) begin
      pins_o.autofd_n = x_state != X_RWAIT;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_end;
    e_state == E_DONE ##1 e_state == E_IDLE;
  endsequence

  a_data_strobe: assert property (!pins_o.autofd_n && epp_active |->
    e_state == E_STROBE && !epp_addr_reg) else $error("data strobe outside data cycle");
  a_addr_strobe: assert property (epp_active && !pins_o.selectin_n |->
    e_state == E_STROBE && epp_addr_reg) else $error("addr strobe outside addr cycle");
  a_init_ctrl: assert property (pins_o.init_n == ctrl_reg[2])
    else $error("init line not from control");
  a_idle_ctrl: assert property (epp_active && e_state == E_IDLE |->
    pins_o.strobe_n == ~ctrl_reg[0] && pins_o.pd_oe == !dir_eff)
    else $error("idle epp cable not from control");
  a_timeout_abort: assert property (e_state == E_STROBE && epp_cnt_reg == TIMEOUT_CYC |=>
    timeout_reg && pslverr_reg ##0 s_cycle_end) else $error("time-out not aborting");
  a_v19_finish: assert property (e_state == E_STROBE && opt_v19 && pins_i.busy
    && epp_cnt_reg < TIMEOUT_CYC |=> s_cycle_end) else $error("cycle not ending on wait");
  a_v19_nostart: assert property (e_state == E_WAIT && pins_i.busy && !epp_tmo |=>
    pins_o.autofd_n && pins_o.selectin_n) else $error("strobe while wait high");
  a_v17_rise: assert property (e_state == E_STROBE && !opt_v19 && !epp_seen_low_reg
    && !epp_tmo |=> e_state == E_STROBE) else $error("ended without wait rise");
  a_flag_clear: assert property (apb_wr && idx == IDX_LINE_STATUS && pwdata[0] && !epp_tmo
    |=> !timeout_reg) else $error("time-out flag not cleared");
  a_fifo_flush: assert property (mode_reg == MODE_SPP |=> count_reg == '0 &&
    count_reg <= DEPTH) else $error("queue not flushed");
  a_epp_gate: assert property (!epp_active && e_state == E_IDLE |=> e_state == E_IDLE)
    else $error("epp cycle without enable");
endmodule // epp_ecp_parallel_port

// file: epp_periph_model.sv
// Purpose: behavioural peripheral on the cable side of the parallel port
// Assumes: one clock shared with the host port, cable levels sampled on pclk
// Notes:   released data lines toggle every cycle so a stale sample never matches
`timescale 1ns/10ps
module epp_periph_model
  import epp_ecp_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // cable from host
  input  wire par_out_s   host_i,
  // behaviour controls
  input  wire logic       hold_busy,
  input  wire logic       mute,
  input  wire logic       drive,
  input  wire logic       v19,
  input  wire logic [7:0] rd_val,
  // cable towards host
  output logic            busy,
  output logic            ack_n,
  output logic [7:0]      pd,
  // observations
  output logic [7:0]      addr_reg,
  output logic [7:0]      data_reg,
  output logic [7:0]      fwd_reg,
  output logic [7:0]      fwd_cnt,
  output logic [7:0]      viol_cnt
);
  logic       strobe_on;
  logic       acked;
  logic       stb_q;
  logic       nstb_q;
  logic [7:0] last_pd;

  assign strobe_on = !host_i.autofd_n || !host_i.selectin_n;
  assign ack_n     = 1'b1;
  assign pd        = (drive || (strobe_on && host_i.strobe_n)) ? rd_val : last_pd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pd <= 8'h00;
      stb_q   <= 1'b0;
      nstb_q  <= 1'b1;
      fwd_reg <= 8'h00;
      fwd_cnt <= 8'h00;
    end else begin
      last_pd <= ~last_pd;
      stb_q   <= strobe_on;
      nstb_q  <= host_i.strobe_n;
      // plain printer strobe only when no byte strobe is active
      if (nstb_q && !host_i.strobe_n && !strobe_on) begin
        fwd_reg <= host_i.pd;
        fwd_cnt <= fwd_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      acked    <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      viol_cnt <= 8'h00;
    end else if (!host_i.init_n) begin
      busy     <= 1'b0;
      acked    <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
    end else if (strobe_on) begin
      if (v19 && !stb_q && busy) begin
        viol_cnt <= viol_cnt + 8'h01;
      end
      if (!acked && busy) begin
        busy <= 1'b0;
      end else if (!acked && !mute) begin
        if (!host_i.strobe_n && !host_i.selectin_n) begin
          addr_reg <= host_i.pd;
        end else if (!host_i.strobe_n) begin
          data_reg <= host_i.pd;
        end
        busy  <= 1'b1;
        acked <= 1'b1;
      end
    end else begin
      acked <= 1'b0;
      busy  <= hold_busy;
    end
  end
endmodule // epp_periph_model

// file: test_epp_ecp_parallel_port.sv
// Purpose: self-checking bench for the parallel host port
// Assumes: APB master tasks, peripheral model on the cable
// Notes:   clock rate parameter lowered so the cycle time-out is 25 cycles
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module test_epp_ecp_parallel_port;
  import epp_ecp_pkg::*;
  localparam int TB_CLK_HZ = 2500000;
  localparam int LIMIT     = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  par_in_s  pins_i;
  par_out_s pins_o;
  logic dma_req, dma_ack;
  logic [7:0] dma_wdata, dma_rdata, rd_val, p_pd, pd_line, rd;
  logic [7:0] addr_reg, data_reg, fwd_reg, fwd_cnt, viol_cnt;
  logic hold_busy, mute, drive, v19, p_busy, p_ack_n, err;
  int   mismatches, total_checks, cycles, wait_n;

  assign pd_line = pins_o.pd_oe ? pins_o.pd : p_pd;
  assign pins_i  = {pd_line, p_busy, p_ack_n, 3'b011};

  epp_ecp_parallel_port #(.CLK_HZ(TB_CLK_HZ), .DEPTH(16)) epp_ecp_parallel_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins_i), .pins_o(pins_o), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata));

  epp_periph_model epp_periph_model_i (
    .pclk(pclk), .presetn(presetn), .host_i(pins_o), .hold_busy(hold_busy), .mute(mute),
    .drive(drive), .v19(v19), .rd_val(rd_val), .busy(p_busy), .ack_n(p_ack_n), .pd(p_pd),
    .addr_reg(addr_reg), .data_reg(data_reg), .fwd_reg(fwd_reg), .fwd_cnt(fwd_cnt),
    .viol_cnt(viol_cnt));

  always #20 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // starts right after an edge, leaves one idle cycle so psel is never set twice at once
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    wait_n = 0;
    do begin
      @(posedge pclk);
      wait_n++;
    end while (pready !== 1'b1 && wait_n < 1000);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      conclude;
    end
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    dma_ack = 0; dma_wdata = 0; hold_busy = 0; mute = 0; drive = 0; v19 = 0;
    rd_val = 8'h00; mismatches = 0; total_checks = 0; cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, IDX_MODE_CTRL, 0); `CHK(rd, 8'h15);
    apb(0, IDX_LINE_CONTROL, 0); `CHK(rd, 8'hC4);
    apb(0, 12'h010, 0); `CHK(err, 1'b1);
    for (int m = 0; m < 8; m++) begin
      apb(1, IDX_MODE_CTRL, {m[2:0], 5'h14});
      apb(0, IDX_MODE_CTRL, 0); `CHK(rd[7:2], {m[2:0], 3'b101});
    end
    apb(0, IDX_QUEUE, 0); `CHK(rd, 8'h10);
    apb(1, IDX_MODE_CTRL, 8'hD4);
    // seventeenth byte must be refused by the full queue
    for (int i = 0; i < 17; i++) apb(1, IDX_QUEUE, 8'h40 + i[7:0]);
    apb(0, IDX_MODE_CTRL, 0); `CHK(rd[1:0], 2'b10);
    for (int i = 0; i < 16; i++) begin
      apb(0, IDX_QUEUE, 0); `CHK(rd, 8'h40 + i[7:0]);
    end
    apb(0, IDX_MODE_CTRL, 0); `CHK(rd[1:0], 2'b01);
    apb(1, IDX_MODE_CTRL, 8'h14); apb(1, IDX_PORT_DATA, 8'hA5);
    `CHK({pins_o.pd_oe, pins_o.pd}, 9'h1A5);
    apb(0, IDX_PORT_DATA, 0); `CHK(rd, 8'hA5);
    apb(1, IDX_MODE_CTRL, 8'h54); apb(1, IDX_QUEUE, 8'h96);
    for (int k = 0; k < 200 && fwd_cnt !== 8'h01; k++) @(posedge pclk);
    `CHK({fwd_cnt, fwd_reg}, 16'h0196);
    apb(1, IDX_MODE_CTRL, 8'h34); apb(1, IDX_LINE_CONTROL, 8'h24);
    drive <= 1'b1; rd_val <= 8'h6B;
    `CHK(pins_o.pd_oe, 1'b0);
    apb(0, IDX_PORT_DATA, 0); `CHK(rd, 8'h6B);
    drive <= 1'b0;
    apb(1, IDX_LINE_CONTROL, 8'h0B);
    `CHK({pins_o.strobe_n, pins_o.autofd_n, pins_o.init_n, pins_o.selectin_n}, 4'h0);
    apb(1, IDX_LINE_CONTROL, 8'h04);
    apb(1, IDX_MODE_CTRL, 8'hC8); `CHK(dma_req, 1'b1);
    dma_wdata <= 8'h77; dma_ack <= 1'b1;
    @(posedge pclk);
    dma_ack <= 1'b0;
    apb(0, IDX_QUEUE, 0); `CHK(rd, 8'h77);
    v19 <= 1'b1; apb(1, IDX_CHIP_OPT, 8'h03); apb(1, IDX_MODE_CTRL, 8'h94);
    `CHK({pins_o.strobe_n, pins_o.autofd_n, pins_o.init_n, pins_o.selectin_n}, 4'hF);
    apb(1, IDX_EPP_ADDR, 8'h5A); `CHK({err, addr_reg}, 9'h05A);
    apb(1, IDX_EPP_DATA3, 8'h3C); `CHK({err, data_reg}, 9'h03C);
    rd_val <= 8'hC3; apb(0, IDX_EPP_DATA0, 0); `CHK({err, rd}, 9'h0C3);
    rd_val <= 8'h3E; apb(0, IDX_EPP_ADDR, 0); `CHK({err, rd}, 9'h03E);
    hold_busy <= 1'b1;
    @(posedge pclk);
    fork
      apb(1, IDX_EPP_DATA0, 8'h11);
      begin repeat (8) @(posedge pclk); hold_busy <= 1'b0; end
    join
    `CHK({viol_cnt, data_reg}, 16'h0011);
    v19 <= 1'b0; apb(1, IDX_CHIP_OPT, 8'h01); hold_busy <= 1'b1;
    @(posedge pclk);
    apb(1, IDX_EPP_DATA0, 8'h22); `CHK({err, data_reg}, 9'h022);
    hold_busy <= 1'b0; v19 <= 1'b1; mute <= 1'b1;
    apb(1, IDX_CHIP_OPT, 8'h03);
    apb(1, IDX_EPP_DATA0, 8'h33); `CHK(err, 1'b1);
    `CHK(wait_n >= 25 && wait_n <= 29, 1'b1);
    mute <= 1'b0;
    apb(0, IDX_LINE_STATUS, 0); `CHK(rd[0], 1'b1);
    apb(1, IDX_LINE_STATUS, 8'h00); apb(0, IDX_LINE_STATUS, 0); `CHK(rd[0], 1'b1);
    apb(1, IDX_LINE_STATUS, 8'h01); apb(0, IDX_LINE_STATUS, 0); `CHK(rd[0], 1'b0);
    conclude;
  end
endmodule // test_epp_ecp_parallel_port
